//--- design/mfi_pkg.sv
package mfi_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MOTION_FLAG = 8'h03;
  localparam logic [7:0] OFS_ALT_CLEAR = 8'h04;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h06;
  localparam logic [7:0] OFS_FEATURE = 8'h09;
  localparam logic [7:0] OFS_FIFO_FLAG = 8'h0a;
  localparam logic [7:0] OFS_INT_STATUS = 8'h14;
  localparam logic [7:0] OFS_FIFO_CTRL = 8'h2d;
  localparam logic [7:0] OFS_QUEUE_LEVEL_FLAG = 8'h2e;
  localparam logic [7:0] OFS_FIFO_ISTAT = 8'h2f;
  localparam logic [7:0] OFS_SVC_CTRL = 8'h31;
  localparam logic [7:0] OFS_LATCH_TIMER = 8'h4a;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_TILT = 0;
  localparam int BIT_FLIP = 1;
  localparam int BIT_ANYM = 2;
  localparam int BIT_SHAKE = 3;
  localparam int BIT_TILT35 = 4;
  localparam int BIT_QUEUE_GROUP = 5;
  localparam int BIT_ACQ = 7;
  localparam int BIT_FEAT_TF = 0;
  localparam int BIT_FQ_EMPTY = 0;
  localparam int BIT_FQ_FULL = 1;
  localparam int BIT_FQ_LEVEL = 2;
  localparam int BIT_FIFO_EN = 5;
  localparam int BIT_REQ_SWAP = 4;
  localparam int BIT_INDIV_CLR = 6;
  localparam int TMR_SEL_LSB = 2;
  localparam int TMR_SEL_MSB = 7;
  localparam logic [7:0] MOTION_MASK = 8'h9f;

  // ---------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] THRESH_RST = 8'h10;
  localparam logic [2:0] FQ_FLAGS_RST = 3'h1;
  localparam int QUEUE_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {MODE_LATCHED, MODE_TEMP, MODE_AUTO, MODE_RSVD} mfi_mode_e;
  typedef enum logic [1:0] {ORI_FLAT, ORI_TILT, ORI_FLIP} mfi_orient_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mfi_reg_req_s;

  typedef struct packed {
    logic anym_lvl;
    logic shake_lvl;
    logic t35_lvl;
    logic anym_hit;
    logic shake_hit;
    logic t35_hit;
    logic tf_qual;
    mfi_orient_e orient;
  } mfi_motion_s;

endpackage

//--- design/mfi_irq_service.sv
`timescale 1ns/1ps
// Contract
// RULE1: Sample-acquired flag sets once for every produced sample.
// RULE2: Reading the motion flag status register clears the sample-acquired flag.
// RULE3: Sample interrupt status sets only when its enable bit is set.
// RULE4: Tilt and flip flags live only while feature bit 0 is set.
// RULE5: Tilt and flip interrupts have separate enables, bits 1:0.
// RULE6: Any-motion flag needs feature bit 2; its status is bit 2.
// RULE7: Shake needs feature bits 3 and 2, not the any-motion enable.
// RULE8: Tilt-35 needs feature bits 4 and 2, not the any-motion enable.
// RULE9: Host should read latched status rather than poll raw motion flags.
// RULE10: Queue flags live only while queue enable bit 5 is set; here they update regardless, bit 5 gates only interrupts.
// RULE11: Queue-empty is flag bit 0, resets to 1, enabled by bit 0.
// RULE12: Queue-full is flag bit 1, resets to 0, enabled by bit 1.
// RULE13: Queue-level is flag bit 2, default threshold 16, enabled by bit 2.
// RULE14: Three servicing modes: latched, temp-latched, auto-clear.
// RULE15: Global mode: write to either clear register clears everything pending.
// RULE16: Global mode ignores write data; only the address makes the clear.
// RULE17: Individual mode: only status writes clear, one bit per written 1.
// RULE18: Individual mode: writing bit 5 clears all queue interrupt flags.
// RULE19: Queue interrupts stay latched; no timeout or auto clear.
// RULE20: Flip interrupt sets on a qualified tilt to flip transition.
// RULE21: Tilt interrupt sets on a qualified flat or flip to tilt transition.
// RULE22: Each event is gated by its enable before its status bit sets.
// RULE23: By default sample/motion request drives pin one, queue request pin two.
// RULE24: Each request is the OR of its pending enabled status bits.
// RULE25: Temp-latched timer expiry clears sample/motion status; sets restart it.
module mfi_irq_service #(
  parameter int TICK_CYCLES = mfi_pkg::TICK_CYCLES,
  parameter int QUEUE_DEPTH = mfi_pkg::QUEUE_DEPTH
) (
  input wire logic clock_in, // 50 MHz core clock
  input wire logic rst_b_in, // Synchronous reset, active low
  input wire logic software_reset_in, // Software reset pulse
  input wire mfi_pkg::mfi_reg_req_s reg_req_in, // Register access strobes
  output logic [7:0] reg_rdata_out, // Read data, one cycle after rd
  input wire logic sample_done_in, // Pulse per produced sample
  input wire logic sample_start_in, // Pulse at start of accumulation
  input wire mfi_pkg::mfi_motion_s motion_in, // Motion detector outputs
  input wire logic queue_access_in, // Pulse on any queue read or write
  input wire logic [5:0] queue_count_in, // Samples held in the queue
  output logic irq_pin_one_out, // Request routed to first pin
  output logic irq_pin_two_out // Request routed to second pin
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic rst;
  logic [7:0] int_en, feat, qctrl, thresh, svc, ltc;
  logic [7:0] next_int_en, next_feat, next_qctrl, next_thresh, next_svc, next_ltc;
  logic [7:0] istat, next_istat;
  logic [2:0] qflags, next_qflags, qistat, next_qistat;
  logic acq_flag, next_acq_flag;
  mfi_pkg::mfi_orient_e tf_prev, next_tf_prev;
  logic [TW-1:0] tick, next_tick;
  logic [5:0] units, next_units;
  logic tmr_run, next_tmr_run;
  logic [7:0] rdata, next_rdata;
  logic pin1, pin2, next_pin1, next_pin2;
  logic [7:0] raw, ev, set, clr;
  logic [2:0] qset, qnow;
  logic wr_stat, wr_alt, indiv, glob_clr, q_clr, expire, req1, req2, q_en;
  mfi_pkg::mfi_mode_e mode;

  assign rst = !rst_b_in || software_reset_in;
  assign mode = mfi_pkg::mfi_mode_e'(ltc[1:0]);
  assign q_en = qctrl[mfi_pkg::BIT_FIFO_EN];
  assign indiv = svc[mfi_pkg::BIT_INDIV_CLR];
  assign wr_stat = reg_req_in.wr && (reg_req_in.addr == mfi_pkg::OFS_INT_STATUS);
  assign wr_alt = reg_req_in.wr && (reg_req_in.addr == mfi_pkg::OFS_ALT_CLEAR);

  // ---------------------------------------------------------------
  // Raw flags and gated events
  // ---------------------------------------------------------------
  // Raw flags follow the detectors and are only meaningful while enabled
  always_comb
  begin
    raw = '0;
    raw[mfi_pkg::BIT_TILT] = feat[mfi_pkg::BIT_FEAT_TF]
      && (motion_in.orient == mfi_pkg::ORI_TILT); // see RULE4
    raw[mfi_pkg::BIT_FLIP] = feat[mfi_pkg::BIT_FEAT_TF]
      && (motion_in.orient == mfi_pkg::ORI_FLIP); // see RULE4
    raw[mfi_pkg::BIT_ANYM] = feat[mfi_pkg::BIT_ANYM] && motion_in.anym_lvl; // see RULE6
    raw[mfi_pkg::BIT_SHAKE] = feat[mfi_pkg::BIT_SHAKE] && feat[mfi_pkg::BIT_ANYM]
      && motion_in.shake_lvl; // see RULE7
    raw[mfi_pkg::BIT_TILT35] = feat[mfi_pkg::BIT_TILT35] && feat[mfi_pkg::BIT_ANYM]
      && motion_in.t35_lvl; // see RULE8
    raw[mfi_pkg::BIT_ACQ] = acq_flag;
  end

  // Events; shake and tilt-35 ignore the any-motion interrupt enable
  always_comb
  begin
    ev = '0;
    ev[mfi_pkg::BIT_TILT] = feat[mfi_pkg::BIT_FEAT_TF] && motion_in.tf_qual
      && (motion_in.orient == mfi_pkg::ORI_TILT)
      && (tf_prev != mfi_pkg::ORI_TILT); // see RULE21
    ev[mfi_pkg::BIT_FLIP] = feat[mfi_pkg::BIT_FEAT_TF] && motion_in.tf_qual
      && (motion_in.orient == mfi_pkg::ORI_FLIP)
      && (tf_prev == mfi_pkg::ORI_TILT); // see RULE20
    ev[mfi_pkg::BIT_ANYM] = feat[mfi_pkg::BIT_ANYM] && motion_in.anym_hit; // see RULE6
    ev[mfi_pkg::BIT_SHAKE] = feat[mfi_pkg::BIT_SHAKE] && feat[mfi_pkg::BIT_ANYM]
      && motion_in.shake_hit; // see RULE7
    ev[mfi_pkg::BIT_TILT35] = feat[mfi_pkg::BIT_TILT35] && feat[mfi_pkg::BIT_ANYM]
      && motion_in.t35_hit; // see RULE8
    ev[mfi_pkg::BIT_ACQ] = sample_done_in;
    set = ev & int_en & mfi_pkg::MOTION_MASK; // see RULE22 RULE5 RULE3
  end

  // ---------------------------------------------------------------
  // Clearing
  // ---------------------------------------------------------------
  // Write data is a don't-care in global mode, the address alone clears
  always_comb
  begin
    glob_clr = !indiv && (wr_stat || wr_alt); // see RULE15 RULE16
    clr = '0;
    if (glob_clr)
    begin
      clr = mfi_pkg::MOTION_MASK; // see RULE15
    end
    else if (indiv && wr_stat)
    begin
      clr = reg_req_in.wdata & mfi_pkg::MOTION_MASK; // see RULE17
    end
    if (mode == mfi_pkg::MODE_TEMP && expire)
    begin
      clr = mfi_pkg::MOTION_MASK; // see RULE25 RULE14
    end
    else if (mode == mfi_pkg::MODE_AUTO)
    begin
      clr = clr | (~raw & 8'h1f); // see RULE14
      clr[mfi_pkg::BIT_ACQ] = clr[mfi_pkg::BIT_ACQ] || sample_start_in;
    end
    q_clr = glob_clr
      || (indiv && wr_stat && reg_req_in.wdata[mfi_pkg::BIT_QUEUE_GROUP]); // see RULE18
  end

  // Set wins over every clear so no event slips through
  always_comb
  begin
    next_istat = (istat & ~clr) | set;
    next_acq_flag = sample_done_in
      || (acq_flag && !(reg_req_in.rd
      && reg_req_in.addr == mfi_pkg::OFS_MOTION_FLAG)); // see RULE1 RULE2
    next_tf_prev = motion_in.tf_qual ? motion_in.orient : tf_prev;
  end

  // ---------------------------------------------------------------
  // Queue flags
  // ---------------------------------------------------------------
  // Flags only move on a queue access, not on every count wiggle
  always_comb
  begin
    qnow[mfi_pkg::BIT_FQ_EMPTY] = (queue_count_in == '0); // see RULE11
    qnow[mfi_pkg::BIT_FQ_FULL] = (32'(queue_count_in) == QUEUE_DEPTH); // see RULE12
    qnow[mfi_pkg::BIT_FQ_LEVEL] = ({2'b00, queue_count_in} >= thresh); // see RULE13
    next_qflags = queue_access_in ? qnow : qflags;
    qset = next_qflags & ~qflags & qctrl[2:0] & {3{q_en}}; // see RULE10
    next_qistat = (qistat & ~{3{q_clr}}) | qset; // see RULE19
  end

  // ---------------------------------------------------------------
  // Temp-latch timer
  // ---------------------------------------------------------------
  // Period is (select + 1) ticks; any new set restarts the count
  always_comb
  begin
    expire = tmr_run && (32'(tick) == TICK_CYCLES - 1)
      && (units == ltc[mfi_pkg::TMR_SEL_MSB:mfi_pkg::TMR_SEL_LSB]);
    next_tick = tick;
    next_units = units;
    next_tmr_run = tmr_run;
    if (set != '0)
    begin
      next_tick = '0; // see RULE25
      next_units = '0;
      next_tmr_run = (mode == mfi_pkg::MODE_TEMP);
    end
    else if (expire || mode != mfi_pkg::MODE_TEMP)
    begin
      next_tmr_run = 1'b0;
    end
    else if (tmr_run)
    begin
      if (32'(tick) == TICK_CYCLES - 1)
      begin
        next_tick = '0;
        next_units = units + 6'h1;
      end
      else
      begin
        next_tick = tick + TW'(1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Register writes, read mux and requests
  // ---------------------------------------------------------------
  always_comb
  begin
    next_int_en = int_en;
    next_feat = feat;
    next_qctrl = qctrl;
    next_thresh = thresh;
    next_svc = svc;
    next_ltc = ltc;
    if (reg_req_in.wr)
    begin
      unique case (reg_req_in.addr)
        mfi_pkg::OFS_INT_ENABLE: next_int_en = reg_req_in.wdata;
        mfi_pkg::OFS_FEATURE: next_feat = reg_req_in.wdata;
        mfi_pkg::OFS_FIFO_CTRL: next_qctrl = reg_req_in.wdata;
        mfi_pkg::OFS_QUEUE_LEVEL_FLAG: next_thresh = reg_req_in.wdata;
        mfi_pkg::OFS_SVC_CTRL: next_svc = reg_req_in.wdata;
        mfi_pkg::OFS_LATCH_TIMER: next_ltc = reg_req_in.wdata;
        default: next_int_en = int_en;
      endcase
    end
    unique case (reg_req_in.addr)
      mfi_pkg::OFS_MOTION_FLAG: next_rdata = raw;
      mfi_pkg::OFS_INT_ENABLE: next_rdata = int_en;
      mfi_pkg::OFS_FEATURE: next_rdata = feat;
      mfi_pkg::OFS_FIFO_FLAG: next_rdata = {5'h00, qflags};
      mfi_pkg::OFS_INT_STATUS: next_rdata = istat;
      mfi_pkg::OFS_FIFO_CTRL: next_rdata = qctrl;
      mfi_pkg::OFS_QUEUE_LEVEL_FLAG: next_rdata = thresh;
      mfi_pkg::OFS_FIFO_ISTAT: next_rdata = {5'h00, qistat};
      mfi_pkg::OFS_SVC_CTRL: next_rdata = svc;
      mfi_pkg::OFS_LATCH_TIMER: next_rdata = ltc;
      default: next_rdata = 8'h00;
    endcase
    req1 = |(istat & int_en & mfi_pkg::MOTION_MASK); // see RULE24
    req2 = q_en && (|(qistat & qctrl[2:0])); // see RULE24
    next_pin1 = svc[mfi_pkg::BIT_REQ_SWAP] ? req2 : req1; // see RULE23
    next_pin2 = svc[mfi_pkg::BIT_REQ_SWAP] ? req1 : req2; // see RULE23
  end

  // Single register stage for all state
  always_ff @(posedge clock_in)
  begin
    if (rst)
    begin
      int_en <= mfi_pkg::REG_RST;
      feat <= mfi_pkg::REG_RST;
      qctrl <= mfi_pkg::REG_RST;
      thresh <= mfi_pkg::THRESH_RST; // see RULE13
      svc <= mfi_pkg::REG_RST;
      ltc <= mfi_pkg::REG_RST;
      istat <= mfi_pkg::REG_RST;
      qflags <= mfi_pkg::FQ_FLAGS_RST; // see RULE11 RULE12
      qistat <= '0;
      acq_flag <= 1'b0;
      tf_prev <= mfi_pkg::ORI_FLAT;
      tick <= '0;
      units <= '0;
      tmr_run <= 1'b0;
      rdata <= mfi_pkg::REG_RST;
      pin1 <= 1'b0;
      pin2 <= 1'b0;
    end
    else
    begin
      int_en <= next_int_en;
      feat <= next_feat;
      qctrl <= next_qctrl;
      thresh <= next_thresh;
      svc <= next_svc;
      ltc <= next_ltc;
      istat <= next_istat;
      qflags <= next_qflags;
      qistat <= next_qistat;
      acq_flag <= next_acq_flag;
      tf_prev <= next_tf_prev;
      tick <= next_tick;
      units <= next_units;
      tmr_run <= next_tmr_run;
      rdata <= next_rdata;
      pin1 <= next_pin1;
      pin2 <= next_pin2;
    end
  end

  assign reg_rdata_out = rdata;
  assign irq_pin_one_out = pin1;
  assign irq_pin_two_out = pin2;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst);

  sequence s_glob_write;
    !indiv && (wr_stat || wr_alt) && set == '0 && qset == '0;
  endsequence
  sequence s_all_idle;
    istat == 8'h00 && qistat == 3'h0;
  endsequence

  property p_acq_set;
    sample_done_in |=> acq_flag;
  endproperty
  a_acq_set: assert property (p_acq_set) else $error("acq flag missed"); // see RULE1

  property p_acq_read_clear;
    acq_flag && reg_req_in.rd && reg_req_in.addr == mfi_pkg::OFS_MOTION_FLAG
      && !sample_done_in |=> !acq_flag;
  endproperty
  a_acq_read_clear: assert property (p_acq_read_clear) else $error("acq not cleared"); // see RULE2

  property p_acq_gate;
    $rose(istat[mfi_pkg::BIT_ACQ]) |-> $past(int_en[mfi_pkg::BIT_ACQ] && sample_done_in);
  endproperty
  a_acq_gate: assert property (p_acq_gate) else $error("acq set while disabled"); // see RULE3

  property p_tf_feature;
    $rose(istat[mfi_pkg::BIT_TILT] || istat[mfi_pkg::BIT_FLIP])
      |-> $past(feat[mfi_pkg::BIT_FEAT_TF]);
  endproperty
  a_tf_feature: assert property (p_tf_feature) else $error("tilt/flip without feature"); // see RULE4

  property p_shake_feature;
    $rose(istat[mfi_pkg::BIT_SHAKE])
      |-> $past(feat[mfi_pkg::BIT_SHAKE] && feat[mfi_pkg::BIT_ANYM]);
  endproperty
  a_shake_feature: assert property (p_shake_feature) else $error("shake without feature"); // see RULE7

  property p_glob_clear;
    s_glob_write |=> s_all_idle;
  endproperty
  a_glob_clear: assert property (p_glob_clear) else $error("global clear failed"); // see RULE15

  property p_queue_group_clear;
    indiv && wr_stat && reg_req_in.wdata[mfi_pkg::BIT_QUEUE_GROUP] && qset == '0
      |=> qistat == 3'h0;
  endproperty
  a_queue_group_clear: assert property (p_queue_group_clear) else $error("queue clr failed"); // see RULE18

  property p_queue_latched;
    qistat[0] && !q_clr |=> qistat[0];
  endproperty
  a_queue_latched: assert property (p_queue_latched) else $error("queue flag dropped"); // see RULE19

  property p_pin_one;
    req1 && !svc[mfi_pkg::BIT_REQ_SWAP] |=> irq_pin_one_out;
  endproperty
  a_pin_one: assert property (p_pin_one) else $error("pin one not driven"); // see RULE24

  // Swap bit trades the two requests, pins follow one cycle later
  property p_pin_swap;
    svc[mfi_pkg::BIT_REQ_SWAP]
      |=> irq_pin_one_out == $past(req2) && irq_pin_two_out == $past(req1);
  endproperty
  a_pin_swap: assert property (p_pin_swap) else $error("swap wrong"); // see RULE23

  // Timer expiry drops every sample and motion bit unless a set collides
  property p_temp_expire;
    expire && mode == mfi_pkg::MODE_TEMP && set == '0
      |=> (istat & mfi_pkg::MOTION_MASK) == 8'h00;
  endproperty
  a_temp_expire: assert property (p_temp_expire) else $error("timer no clear"); // see RULE25

  // Level interrupt can only rise from an access while the queue is enabled
  property p_qlevel_set;
    $rose(qistat[mfi_pkg::BIT_FQ_LEVEL])
      |-> $past(q_en && qctrl[mfi_pkg::BIT_FQ_LEVEL] && queue_access_in);
  endproperty
  a_qlevel_set: assert property (p_qlevel_set) else $error("level ungated"); // see RULE10

  // Written ones clear, written zeros leave the bit alone
  property p_indiv_clear;
    indiv && wr_stat && set == '0 && mode == mfi_pkg::MODE_LATCHED
      |=> istat == ($past(istat) & ~$past(reg_req_in.wdata));
  endproperty
  a_indiv_clear: assert property (p_indiv_clear) else $error("bad indiv clear"); // see RULE17

endmodule

//--- dv/mfi_host_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Host processor on the register bus
// ---------------------------------------------------------------
module mfi_host_model (
  input wire logic clock_in, // Core clock
  output mfi_pkg::mfi_reg_req_s reg_req_out, // Requests to the block
  input wire logic [7:0] reg_rdata_in // Read data from the block
);
  initial reg_req_out = '0;

  // Idle bus shows inverted leftovers so stale values never look valid
  task automatic idle();
    reg_req_out.wr = 1'b0;
    reg_req_out.rd = 1'b0;
    reg_req_out.addr = ~reg_req_out.addr;
    reg_req_out.wdata = ~reg_req_out.wdata;
  endtask

  // Write held across exactly one taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_req_out = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    #1;
    idle();
  endtask

  // Read held across one taking edge, data picked up just after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock_in);
    #1;
    reg_req_out = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock_in);
    #1;
    d = reg_rdata_in;
    idle();
  endtask
endmodule

//--- dv/mfi_irq_service_tb.sv
`timescale 1ns/1ps
module mfi_irq_service_tb;
  localparam logic [7:0] A_FLAG = mfi_pkg::OFS_MOTION_FLAG;
  localparam logic [7:0] A_ALT = mfi_pkg::OFS_ALT_CLEAR;
  localparam logic [7:0] A_EN = mfi_pkg::OFS_INT_ENABLE;
  localparam logic [7:0] A_FEAT = mfi_pkg::OFS_FEATURE;
  localparam logic [7:0] A_QFLAG = mfi_pkg::OFS_FIFO_FLAG;
  localparam logic [7:0] A_IST = mfi_pkg::OFS_INT_STATUS;
  localparam logic [7:0] A_QCTL = mfi_pkg::OFS_FIFO_CTRL;
  localparam logic [7:0] A_QIST = mfi_pkg::OFS_FIFO_ISTAT;
  localparam logic [7:0] A_SVC = mfi_pkg::OFS_SVC_CTRL;
  localparam logic [7:0] A_TMR = mfi_pkg::OFS_LATCH_TIMER;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic sw_rst = 1'b0;
  mfi_pkg::mfi_reg_req_s reg_req;
  logic [7:0] rdata;
  logic s_done = 1'b0;
  logic s_start = 1'b0;
  mfi_pkg::mfi_motion_s mot = '0;
  logic q_acc = 1'b0;
  logic [5:0] q_cnt = 6'h00;
  logic pin_one;
  logic pin_two;
  logic [7:0] rv;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;

  // Short latch tick keeps the temp-latch wait to a few cycles
  mfi_irq_service #(.TICK_CYCLES(4), .QUEUE_DEPTH(32)) dut_u (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .software_reset_in(sw_rst),
    .reg_req_in(reg_req), .reg_rdata_out(rdata), .sample_done_in(s_done),
    .sample_start_in(s_start), .motion_in(mot), .queue_access_in(q_acc),
    .queue_count_in(q_cnt), .irq_pin_one_out(pin_one), .irq_pin_two_out(pin_two)
  );
  mfi_host_model host_u (
    .clock_in(clock_in), .reg_req_out(reg_req), .reg_rdata_in(rdata)
  );

  always #10 clock_in = ~clock_in;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s saw %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_u.rd(a, rv);
    chk(rv, exp, "register read");
  endtask
  task automatic pins(input logic [1:0] exp);
    chk({6'h00, pin_two, pin_one}, {6'h00, exp}, "request pins");
  endtask
  task automatic sample();
    s_done = 1'b1;
    step(1);
    s_done = 1'b0;
    step(2);
  endtask
  task automatic tfq(input mfi_pkg::mfi_orient_e o);
    mot.orient = o;
    mot.tf_qual = 1'b1;
    step(1);
    mot.tf_qual = 1'b0;
    step(2);
  endtask
  task automatic hits();
    {mot.anym_hit, mot.shake_hit, mot.t35_hit} = 3'b111;
    step(1);
    {mot.anym_hit, mot.shake_hit, mot.t35_hit} = 3'b000;
    step(2);
  endtask
  task automatic qacc(input logic [5:0] c);
    q_cnt = c;
    q_acc = 1'b1;
    step(1);
    q_acc = 1'b0;
    step(2);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rchk(A_QFLAG, 8'h01);
    rchk(mfi_pkg::OFS_QUEUE_LEVEL_FLAG, 8'h10);
    rchk(8'h7f, 8'h00);
    pins(2'b00);
  endtask

  task automatic t_sample();
    sample();
    pins(2'b00);
    rchk(A_FLAG, 8'h80);
    rchk(A_FLAG, 8'h00);
    host_u.wr(A_EN, 8'h80);
    rchk(A_EN, 8'h80);
    sample();
    pins(2'b01);
    host_u.wr(A_ALT, 8'h00);
    step(1);
    pins(2'b00);
  endtask

  task automatic t_motion();
    host_u.wr(A_EN, 8'h1f);
    host_u.wr(A_FEAT, 8'h18);
    hits();
    rchk(A_IST, 8'h00);
    host_u.wr(A_FEAT, 8'h1c);
    host_u.wr(A_EN, 8'h18);
    hits();
    rchk(A_IST, 8'h18);
    host_u.wr(A_SVC, 8'h40);
    host_u.wr(A_ALT, 8'hff);
    rchk(A_IST, 8'h18);
    host_u.wr(A_IST, 8'h08);
    rchk(A_IST, 8'h10);
    pins(2'b01);
    host_u.wr(A_IST, 8'h10);
    step(1);
    pins(2'b00);
    host_u.wr(A_SVC, 8'h00);
  endtask

  task automatic t_tilt();
    host_u.wr(A_FEAT, 8'h00);
    host_u.wr(A_EN, 8'h03);
    tfq(mfi_pkg::ORI_TILT);
    rchk(A_IST, 8'h00);
    rchk(A_FLAG, 8'h80);
    host_u.wr(A_FEAT, 8'h01);
    tfq(mfi_pkg::ORI_FLAT);
    host_u.wr(A_EN, 8'h02);
    tfq(mfi_pkg::ORI_TILT);
    rchk(A_IST, 8'h00);
    tfq(mfi_pkg::ORI_FLIP);
    rchk(A_IST, 8'h02);
    host_u.wr(A_EN, 8'h03);
    tfq(mfi_pkg::ORI_TILT);
    rchk(A_IST, 8'h03);
    rchk(A_FLAG, 8'h01);
    host_u.wr(A_IST, 8'h00);
    rchk(A_IST, 8'h00);
  endtask

  task automatic t_queue();
    host_u.wr(A_QCTL, 8'h27);
    qacc(6'd16);
    rchk(A_QFLAG, 8'h04);
    pins(2'b10);
    qacc(6'd32);
    rchk(A_QIST, 8'h06);
    // Temp latch clears the sample request, never the queue one
    host_u.wr(A_EN, 8'h80);
    host_u.wr(A_TMR, 8'h01);
    sample();
    pins(2'b11);
    step(8);
    pins(2'b10);
    host_u.wr(A_SVC, 8'h10);
    step(1);
    pins(2'b01);
    host_u.wr(A_SVC, 8'h00);
    host_u.wr(A_TMR, 8'h02);
    sample();
    pins(2'b11);
    s_start = 1'b1;
    step(1);
    s_start = 1'b0;
    step(2);
    pins(2'b10);
    host_u.wr(A_TMR, 8'h00);
    host_u.wr(A_SVC, 8'h40);
    host_u.wr(A_IST, 8'h1f);
    rchk(A_QIST, 8'h06);
    host_u.wr(A_IST, 8'h20);
    rchk(A_QIST, 8'h00);
    host_u.wr(A_SVC, 8'h00);
    qacc(6'd0);
    rchk(A_QIST, 8'h01);
    host_u.wr(A_ALT, 8'h5a);
    rchk(A_QIST, 8'h00);
    host_u.wr(A_QCTL, 8'h07);
    qacc(6'd16);
    rchk(A_QIST, 8'h00);
    sw_rst = 1'b1;
    step(1);
    sw_rst = 1'b0;
    rchk(A_QFLAG, 8'h01);
  endtask

  // ---------------------------------------------------------------
  // Verdict, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_total == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      $display("mismatch at %0t: run did not finish", $time);
      test_done();
    end
  end

  initial
  begin
    step(16);
    rst_b_in = 1'b1;
    step(1);
    t_reset();
    t_sample();
    t_motion();
    t_tilt();
    t_queue();
    test_done();
  end
endmodule
